// >>> design/pkt_regs_consts.svh
// offsets, field positions and reset values of the packet store register bank
`ifndef PKT_REGS_CONSTS_SVH
`define PKT_REGS_CONSTS_SVH
`define OFF_REQ_INFO 32'h0000_0000
`define OFF_STORE_CTRL 32'h0000_0004
`define RQ_TID_HI 31
`define RQ_TID_LO 24
`define RQ_PRIO_HI 18
`define RQ_PRIO_LO 17
`define RQ_CRF_BIT 16
`define RQ_DEST_HI 15
`define RQ_DEST_LO 0
`define RST_TID 8'h00
`define RST_PRIO 2'h1
`define RST_CRF 1'h0
`define RST_DEST 16'h0000
`define SC_RXFC_ONLY_BIT 31
`define SC_UNIFIED_BIT 30
`define SC_TXFC_LIVE_BIT 29
`define SC_REORDER_BIT 28
`define SC_TXSIZE_HI 26
`define SC_TXSIZE_LO 16
`define SC_FORCE_RXFC_BIT 15
`define SC_RXSIZE_HI 7
`define SC_RXSIZE_LO 0
`endif

// >>> design/pkt_regs_pkg.sv
// types shared by the packet store register bank
`default_nettype none
package pkt_regs_pkg;
    typedef struct packed {
        logic [7:0] tid;
        logic [1:0] prio;
        logic crf;
        logic [15:0] dest;
    } req_hdr_t;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [31:0] addr;
        logic [31:0] wdata;
    } cfg_req_t;
endpackage
`default_nettype wire

// >>> design/req_info_store.sv
// maintenance request header store with auto-increment of transaction id
`default_nettype none
`include "pkt_regs_consts.svh"
module req_info_store
    import pkt_regs_pkg::*;
#(
    parameter bit CRF_SUPPORT = 1'b1
)
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic wr,
    input wire logic [31:0] wdata,
    input wire logic sent,
    output req_hdr_t hdr
);
    req_hdr_t next_hdr;

    always_comb
    begin
        next_hdr = hdr;
        if (wr)
        begin
            next_hdr.tid = wdata[`RQ_TID_HI:`RQ_TID_LO];
            next_hdr.prio = wdata[`RQ_PRIO_HI:`RQ_PRIO_LO];
            if (CRF_SUPPORT)
            begin
                next_hdr.crf = wdata[`RQ_CRF_BIT];
            end
            next_hdr.dest = wdata[`RQ_DEST_HI:`RQ_DEST_LO];
        end
        // a request sent in the write cycle still bumps the written id
        if (sent)
        begin
            next_hdr.tid = next_hdr.tid + 8'h01;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            hdr <= '{tid: `RST_TID, prio: `RST_PRIO, crf: `RST_CRF, dest: `RST_DEST};
        end
        else
        begin
            hdr <= next_hdr;
        end
    end

    chk_tid_bump: assert property (@(posedge clk) disable iff (!nrst)
        sent && !wr |=> hdr.tid == $past(hdr.tid) + 8'h01)
        else $error("tid did not advance after a request");
    chk_crf_locked: assert property (@(posedge clk) disable iff (!nrst)
        !CRF_SUPPORT |-> hdr.crf == 1'b0)
        else $error("crf changed without crf support");
endmodule
`default_nettype wire

// >>> design/pkt_store_regs.sv
// packet store control register and maintenance request header register
`default_nettype none
`include "pkt_regs_consts.svh"
module pkt_store_regs
    import pkt_regs_pkg::*;
#(
    parameter bit RXFC_ONLY = 1'b0,
    parameter bit UNIFIED_CLK = 1'b0,
    parameter bit TX_REORDER = 1'b0,
    parameter bit CRF_SUPPORT = 1'b1,
    parameter logic [10:0] TX_DEPTH = 11'h010,
    parameter logic [7:0] RX_DEPTH = 8'h10
)
(
    input wire logic clk,
    input wire logic nrst,
    // buffer-space configuration port
    input wire cfg_req_t buf_req,
    output logic [31:0] buf_rdata,
    output logic buf_rvalid,
    // maintenance path, from local maintenance port or link partner only
    input wire cfg_req_t maint_req,
    output logic [31:0] maint_rdata,
    output logic maint_rvalid,
    // one pulse per maintenance request sent
    input wire logic maint_sent,
    output req_hdr_t maint_hdr,
    output logic txfc_active
);
    // ****************************************
    // store control register
    // ****************************************
    logic force_rxfc;
    logic next_force_rxfc;
    logic [31:0] next_buf_rdata;
    logic next_buf_rvalid;

    function automatic logic hit(input cfg_req_t r, input logic [31:0] off);
        hit = r.addr == off;
    endfunction

    always_comb
    begin
        next_force_rxfc = force_rxfc;
        if (buf_req.wr && hit(buf_req, `OFF_STORE_CTRL) && !RXFC_ONLY)
        begin
            next_force_rxfc = buf_req.wdata[`SC_FORCE_RXFC_BIT];
        end
    end

    assign txfc_active = !RXFC_ONLY && !force_rxfc;

    always_comb
    begin
        next_buf_rdata = 32'h0000_0000;
        next_buf_rvalid = buf_req.rd;
        if (buf_req.rd && hit(buf_req, `OFF_STORE_CTRL))
        begin
            next_buf_rdata[`SC_RXFC_ONLY_BIT] = RXFC_ONLY;
            next_buf_rdata[`SC_UNIFIED_BIT] = UNIFIED_CLK;
            next_buf_rdata[`SC_TXFC_LIVE_BIT] = txfc_active;
            next_buf_rdata[`SC_REORDER_BIT] = TX_REORDER;
            next_buf_rdata[`SC_TXSIZE_HI:`SC_TXSIZE_LO] = TX_DEPTH;
            next_buf_rdata[`SC_FORCE_RXFC_BIT] = force_rxfc;
            next_buf_rdata[`SC_RXSIZE_HI:`SC_RXSIZE_LO] = RX_DEPTH;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            force_rxfc <= RXFC_ONLY;
        end
        else
        begin
            force_rxfc <= next_force_rxfc;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            buf_rdata <= 32'h0000_0000;
            buf_rvalid <= 1'b0;
        end
        else
        begin
            buf_rdata <= next_buf_rdata;
            buf_rvalid <= next_buf_rvalid;
        end
    end

    // ****************************************
    // maintenance request info register
    // ****************************************
    logic info_wr;
    logic [31:0] next_maint_rdata;
    logic next_maint_rvalid;

    // only the maintenance path decodes this register
    assign info_wr = maint_req.wr && hit(maint_req, `OFF_REQ_INFO);

    req_info_store #(.CRF_SUPPORT(CRF_SUPPORT)) u_info
    (
        .clk(clk),
        .nrst(nrst),
        .wr(info_wr),
        .wdata(maint_req.wdata),
        .sent(maint_sent),
        .hdr(maint_hdr)
    );

    always_comb
    begin
        next_maint_rdata = 32'h0000_0000;
        next_maint_rvalid = maint_req.rd;
        if (maint_req.rd && hit(maint_req, `OFF_REQ_INFO))
        begin
            next_maint_rdata[`RQ_TID_HI:`RQ_TID_LO] = maint_hdr.tid;
            next_maint_rdata[`RQ_PRIO_HI:`RQ_PRIO_LO] = maint_hdr.prio;
            next_maint_rdata[`RQ_CRF_BIT] = maint_hdr.crf;
            next_maint_rdata[`RQ_DEST_HI:`RQ_DEST_LO] = maint_hdr.dest;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            maint_rdata <= 32'h0000_0000;
            maint_rvalid <= 1'b0;
        end
        else
        begin
            maint_rdata <= next_maint_rdata;
            maint_rvalid <= next_maint_rvalid;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    sequence s_ctrl_write;
        buf_req.wr && buf_req.addr == `OFF_STORE_CTRL;
    endsequence

    sequence s_ctrl_read;
        buf_req.rd && buf_req.addr == `OFF_STORE_CTRL;
    endsequence

    sequence s_info_write;
        maint_req.wr && maint_req.addr == `OFF_REQ_INFO;
    endsequence

    sequence s_info_read;
        maint_req.rd && maint_req.addr == `OFF_REQ_INFO;
    endsequence

    // control register: build bits and override
    chk_force_locked: assert property (@(posedge clk) disable iff (!nrst)
        RXFC_ONLY |-> force_rxfc && !txfc_active)
        else $error("force bit moved in rx-only build");

    chk_force_write: assert property (@(posedge clk) disable iff (!nrst)
        s_ctrl_write ##0 !RXFC_ONLY
        |=> force_rxfc == $past(buf_req.wdata[`SC_FORCE_RXFC_BIT]))
        else $error("force bit not written");

    chk_force_reset: assert property (@(posedge clk) disable iff (!nrst)
        $rose(nrst) |-> force_rxfc == RXFC_ONLY)
        else $error("force bit reset value wrong");

    chk_ctrl_read: assert property (@(posedge clk) disable iff (!nrst)
        s_ctrl_read
        |=> buf_rvalid && buf_rdata[27] == 1'b0 && buf_rdata[14:8] == 7'h00
            && buf_rdata[`SC_TXFC_LIVE_BIT] == !$past(force_rxfc)
            && buf_rdata[`SC_TXSIZE_HI:`SC_TXSIZE_LO] == TX_DEPTH
            && buf_rdata[`SC_RXSIZE_HI:`SC_RXSIZE_LO] == RX_DEPTH)
        else $error("control readback wrong");

    chk_rx_only_bit: assert property (@(posedge clk) disable iff (!nrst)
        s_ctrl_read |=> buf_rdata[`SC_RXFC_ONLY_BIT] == RXFC_ONLY)
        else $error("rx-only build bit wrong");

    chk_unified_bit: assert property (@(posedge clk) disable iff (!nrst)
        s_ctrl_read |=> buf_rdata[`SC_UNIFIED_BIT] == UNIFIED_CLK)
        else $error("single-clock build bit wrong");

    chk_reorder_bit: assert property (@(posedge clk) disable iff (!nrst)
        s_ctrl_read |=> buf_rdata[`SC_REORDER_BIT] == TX_REORDER)
        else $error("reorder build bit wrong");

    chk_force_readback: assert property (@(posedge clk) disable iff (!nrst)
        s_ctrl_read |=> buf_rdata[`SC_FORCE_RXFC_BIT] == $past(force_rxfc))
        else $error("force bit readback wrong");

    chk_tx_depth: assert property (@(posedge clk) disable iff (!nrst)
        s_ctrl_read |=> buf_rdata[`SC_TXSIZE_HI:`SC_TXSIZE_LO] == TX_DEPTH)
        else $error("transmit depth field wrong");

    chk_rx_depth: assert property (@(posedge clk) disable iff (!nrst)
        s_ctrl_read |=> buf_rdata[`SC_RXSIZE_HI:`SC_RXSIZE_LO] == RX_DEPTH)
        else $error("receive depth field wrong");

    chk_buf_unmapped: assert property (@(posedge clk) disable iff (!nrst)
        buf_req.rd && buf_req.addr != `OFF_STORE_CTRL
        |=> buf_rvalid && buf_rdata == 32'h0000_0000)
        else $error("unmapped buffer read not zero");

    // request info register
    chk_info_isolated: assert property (@(posedge clk) disable iff (!nrst)
        !maint_req.wr && !maint_sent |=> maint_hdr == $past(maint_hdr))
        else $error("info register changed without maintenance access");

    chk_buf_no_info: assert property (@(posedge clk) disable iff (!nrst)
        buf_req.wr && !info_wr && !maint_sent
        |=> maint_hdr == $past(maint_hdr))
        else $error("buffer-space write reached info register");

    chk_info_read: assert property (@(posedge clk) disable iff (!nrst)
        s_info_read
        |=> maint_rvalid && maint_rdata[23:19] == 5'h00
            && maint_rdata[`RQ_TID_HI:`RQ_TID_LO] == $past(maint_hdr.tid))
        else $error("info readback wrong");

    chk_prio_read: assert property (@(posedge clk) disable iff (!nrst)
        s_info_read |=> maint_rdata[`RQ_PRIO_HI:`RQ_PRIO_LO] == $past(maint_hdr.prio))
        else $error("priority readback wrong");

    chk_crf_read: assert property (@(posedge clk) disable iff (!nrst)
        s_info_read |=> maint_rdata[`RQ_CRF_BIT] == $past(maint_hdr.crf))
        else $error("crf readback wrong");

    chk_dest_read: assert property (@(posedge clk) disable iff (!nrst)
        s_info_read |=> maint_rdata[`RQ_DEST_HI:`RQ_DEST_LO] == $past(maint_hdr.dest))
        else $error("destination readback wrong");

    chk_info_write: assert property (@(posedge clk) disable iff (!nrst)
        s_info_write ##0 !maint_sent
        |=> maint_hdr.dest == $past(maint_req.wdata[15:0])
            && maint_hdr.prio == $past(maint_req.wdata[18:17]))
        else $error("info write not stored");

    chk_tid_write: assert property (@(posedge clk) disable iff (!nrst)
        s_info_write ##0 !maint_sent
        |=> maint_hdr.tid == $past(maint_req.wdata[`RQ_TID_HI:`RQ_TID_LO]))
        else $error("tid write not stored");

    chk_tid_on_write: assert property (@(posedge clk) disable iff (!nrst)
        s_info_write ##0 maint_sent
        |=> maint_hdr.tid == $past(maint_req.wdata[`RQ_TID_HI:`RQ_TID_LO]) + 8'h01)
        else $error("tid not bumped past written value");

    chk_crf_write: assert property (@(posedge clk) disable iff (!nrst)
        s_info_write ##0 !maint_sent
        |=> maint_hdr.crf == (CRF_SUPPORT && $past(maint_req.wdata[`RQ_CRF_BIT])))
        else $error("crf write handling wrong");

    chk_info_unmapped: assert property (@(posedge clk) disable iff (!nrst)
        maint_req.rd && maint_req.addr != `OFF_REQ_INFO
        |=> maint_rvalid && maint_rdata == 32'h0000_0000)
        else $error("unmapped maintenance read not zero");

    chk_tid_reset: assert property (@(posedge clk) disable iff (!nrst)
        $rose(nrst) |-> maint_hdr.tid == `RST_TID)
        else $error("tid reset value wrong");

    chk_prio_reset: assert property (@(posedge clk) disable iff (!nrst)
        $rose(nrst) |-> maint_hdr.prio == `RST_PRIO)
        else $error("priority reset value wrong");

    chk_crf_reset: assert property (@(posedge clk) disable iff (!nrst)
        $rose(nrst) |-> maint_hdr.crf == `RST_CRF)
        else $error("crf reset value wrong");

    chk_dest_reset: assert property (@(posedge clk) disable iff (!nrst)
        $rose(nrst) |-> maint_hdr.dest == `RST_DEST)
        else $error("destination reset value wrong");
endmodule
`default_nettype wire

// >>> test/cfg_master.sv
// bus master model issuing configuration and maintenance requests
`default_nettype none
module cfg_master
    import pkt_regs_pkg::*;
(
    input wire logic clk,
    input wire logic [31:0] buf_rdata,
    input wire logic [31:0] maint_rdata,
    output cfg_req_t buf_req,
    output cfg_req_t maint_req,
    output logic maint_sent
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        buf_req = '0;
        maint_req = '0;
        maint_sent = 1'b0;
    end
    // one word access, optionally with a sent pulse in the same cycle
    task automatic access(input bit mp, input bit w, input logic [31:0] a, input logic [31:0] d,
        input bit snd, output logic [31:0] q);
        cfg_req_t r;
        r = '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge clk);
        #1;
        if (mp) maint_req = r; else buf_req = r;
        maint_sent = snd;
        @(posedge clk);
        #1;
        q = mp ? maint_rdata : buf_rdata;
        // released lines show inverted values, not stale ones
        r = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
        if (mp) maint_req = r; else buf_req = r;
        maint_sent = 1'b0;
    endtask
    task automatic pulse();
        @(posedge clk);
        #1 maint_sent = 1'b1;
        @(posedge clk);
        #1 maint_sent = 1'b0;
    endtask
endmodule
`default_nettype wire

// >>> test/buffer_and_maint_request_regs_tb.sv
// self-checking bench for the packet store register bank
`default_nettype none
module buffer_and_maint_request_regs_tb;
    import pkt_regs_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, nrst, maint_sent, buf_rvalid, maint_rvalid, txfc_active;
    cfg_req_t buf_req, maint_req;
    logic [31:0] buf_rdata, maint_rdata, q, d;
    req_hdr_t maint_hdr;
    logic [31:0] buf_rdata_rx, maint_rdata_rx;
    logic txfc_active_rx;
    int failures, total_checks, i;
    pkt_store_regs #(.TX_REORDER(1'b1), .TX_DEPTH(11'h008), .RX_DEPTH(8'h20)) DUT (.clk(clk),
        .nrst(nrst), .buf_req(buf_req), .buf_rdata(buf_rdata), .buf_rvalid(buf_rvalid),
        .maint_req(maint_req), .maint_rdata(maint_rdata), .maint_rvalid(maint_rvalid),
        .maint_sent(maint_sent), .maint_hdr(maint_hdr), .txfc_active(txfc_active));
    // second build: rx flow control only, single clock, no crf support
    pkt_store_regs #(.RXFC_ONLY(1'b1), .UNIFIED_CLK(1'b1), .CRF_SUPPORT(1'b0),
        .TX_DEPTH(11'h020), .RX_DEPTH(8'h08)) DUT_RXONLY (.clk(clk), .nrst(nrst),
        .buf_req(buf_req), .buf_rdata(buf_rdata_rx), .buf_rvalid(), .maint_req(maint_req),
        .maint_rdata(maint_rdata_rx), .maint_rvalid(), .maint_sent(maint_sent),
        .maint_hdr(), .txfc_active(txfc_active_rx));
    cfg_master m (.clk(clk), .buf_rdata(buf_rdata), .maint_rdata(maint_rdata),
        .buf_req(buf_req), .maint_req(maint_req), .maint_sent(maint_sent));
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    function automatic logic [31:0] exp_ctrl(input logic f);
        return {1'b0, 1'b0, !f, 1'b1, 1'b0, 11'h008, f, 7'h00, 8'h20};
    endfunction
    function automatic logic [31:0] exp_ctrl_rx();
        return {1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 11'h020, 1'b1, 7'h00, 8'h08};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_hdr(input logic [31:0] w);
        chk({5'h00, maint_hdr}, {5'h00, w[31:24], w[18:0]});
    endtask
    task automatic results();
        $display("checks=%0d failures=%0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        failures = 0;
        total_checks = 0;
        nrst = 1'b0;
        void'($urandom(32'h0F59403C));
        repeat (6) @(posedge clk);
        #1 nrst = 1'b1;
        m.access(1'b0, 1'b0, 32'h0000_0004, 32'h0, 1'b0, q);
        chk(q, exp_ctrl(1'b0));
        chk({31'h0, buf_rvalid}, 32'h1);
        chk({31'h0, txfc_active}, 32'h1);
        chk(buf_rdata_rx, exp_ctrl_rx());
        chk({31'h0, txfc_active_rx}, 32'h0);
        m.access(1'b1, 1'b0, 32'h0, 32'h0, 1'b0, q);
        chk(q, 32'h0002_0000);
        chk({31'h0, maint_rvalid}, 32'h1);
        $display("test reset values ended");
        for (i = 0; i < 2; i++)
        begin
            d = i ? 32'h0 : 32'hFFFF_FFFF;
            m.access(1'b0, 1'b1, 32'h0000_0004, d, 1'b0, q);
            m.access(1'b0, 1'b0, 32'h0000_0004, 32'h0, 1'b0, q);
            chk(q, exp_ctrl(d[15]));
            chk(buf_rdata_rx, exp_ctrl_rx());
            chk({31'h0, txfc_active}, {31'h0, d[15] ^ 1'b1});
        end
        $display("test force flow control ended");
        repeat (8)
        begin
            d = $urandom;
            m.access(1'b1, 1'b1, 32'h0, d, 1'b0, q);
            m.access(1'b1, 1'b0, 32'h0, 32'h0, 1'b0, q);
            chk(q, d & 32'hFF07_FFFF);
            chk_hdr(d);
            chk(maint_rdata_rx, d & 32'hFF06_FFFF);
        end
        $display("test random header fields ended");
        d = {8'hFE, 5'h00, 19'($urandom)};
        m.access(1'b1, 1'b1, 32'h0, d, 1'b0, q);
        repeat (3) m.pulse();
        chk_hdr({8'h01, d[23:0]});
        m.access(1'b1, 1'b1, 32'h0, {8'h7F, d[23:0]}, 1'b1, q);
        chk_hdr({8'h80, d[23:0]});
        $display("test transaction id increment ended");
        m.access(1'b0, 1'b1, 32'h0, ~d, 1'b0, q);
        m.access(1'b0, 1'b0, 32'h0, 32'h0, 1'b0, q);
        chk(q, 32'h0);
        chk_hdr({8'h80, d[23:0]});
        m.access(1'b1, 1'b0, 32'h0000_0008, 32'h0, 1'b0, q);
        chk(q, 32'h0);
        m.access(1'b0, 1'b1, 32'h0000_0008, 32'hFFFF_FFFF, 1'b0, q);
        m.access(1'b0, 1'b0, 32'h0000_0004, 32'h0, 1'b0, q);
        chk(q, exp_ctrl(1'b0));
        $display("test isolation and unmapped ended");
        results();
    end
endmodule
`default_nettype wire
